// >>> src/ddr2_cmd_ctrl.sv
// DDR2 command and control input front end: sampling, decode, power states, termination and masking.
`timescale 1ns/1ns
module ddr2_cmd_ctrl #(
    parameter int BURST_BEATS = ddr2_cmd_pkg::BURST_BEATS
) (
    input  wire logic                               ref_clk,
    input  wire logic                               sys_rst,
    input  wire logic                               ck,
    input  wire logic                               ck_n,
    input  wire logic                               cke,
    input  wire logic                               cs_n,
    input  wire logic                               ras_n,
    input  wire logic                               cas_n,
    input  wire logic                               we_n,
    input  wire logic                               odt,
    input  wire logic [ddr2_cmd_pkg::BANK_W-1:0]    ba,
    input  wire logic [ddr2_cmd_pkg::ADDR_W-1:0]    addr,
    input  wire logic [ddr2_cmd_pkg::DM_W-1:0]      dm,
    input  wire logic                               dqs,
    input  wire logic [ddr2_cmd_pkg::DQ_W-1:0]      dq_in,
    input  wire logic [2*ddr2_cmd_pkg::DQ_W-1:0]    rd_data,
    input  wire logic                               rd_en,
    output logic [ddr2_cmd_pkg::DQ_W-1:0]           dq_out,
    output logic                                    dq_oe,
    output ddr2_cmd_pkg::cmd_s                      cmd,
    output logic                                    cmd_valid,
    output logic [ddr2_cmd_pkg::NUM_BANKS-1:0]      bank_open,
    output ddr2_cmd_pkg::pwr_e                      pwr_state,
    output logic                                    clk_en,
    output logic                                    cmd_buf_en,
    output logic                                    ctl_buf_en,
    output logic                                    drv_en,
    output logic [ddr2_cmd_pkg::DQ_W+2*ddr2_cmd_pkg::DM_W-1:0] term_en,
    output logic [ddr2_cmd_pkg::DQ_W-1:0]           wr_data,
    output logic [ddr2_cmd_pkg::DM_W-1:0]           wr_strb,
    output logic                                    wr_valid
);

    localparam int PW = ddr2_cmd_pkg::PIN_W;
    localparam int TW = ddr2_cmd_pkg::DQ_W + 2 * ddr2_cmd_pkg::DM_W;

    // ****************************************************************
    // Pin synchroniser and filter
    // ****************************************************************
    logic [PW-1:0] pins;
    logic [PW-1:0] sync1;
    logic [PW-1:0] sync2;
    logic [PW-1:0] sync3;
    logic [PW-1:0] filt;

    assign pins = {ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm, dqs, dq_in};

    // Three stages; the first is read only by the second.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // A bit changes only once the second and third stages agree, which rejects one-cycle glitches.
    genvar gi;
    generate
        for (gi = 0; gi < PW; gi++) begin : g_filt
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    filt[gi] <= 1'b0;
                end else if (sync2[gi] == sync3[gi]) begin
                    filt[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    logic                                   f_ck;
    logic                                   f_ck_n;
    logic                                   f_cke;
    logic [3:0]                             f_code;
    logic                                   f_odt;
    logic [ddr2_cmd_pkg::BANK_W-1:0]        f_ba;
    logic [ddr2_cmd_pkg::ADDR_W-1:0]        f_addr;
    logic [ddr2_cmd_pkg::DM_W-1:0]          f_dm;
    logic                                   f_dqs;
    logic [ddr2_cmd_pkg::DQ_W-1:0]          f_dq;

    assign {f_ck, f_ck_n, f_cke, f_code, f_odt, f_ba, f_addr, f_dm, f_dqs, f_dq} = filt;

    // ****************************************************************
    // Clock crossing and strobe edge detection
    // ****************************************************************
    logic [1:0] ck_prev;
    logic       dqs_prev;
    logic       ck_rise;
    logic       ck_fall;
    logic       dqs_edge;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ck_prev  <= 2'h1;
            dqs_prev <= 1'b0;
        end else begin
            ck_prev  <= {f_ck, f_ck_n};
            dqs_prev <= f_dqs;
        end
    end

    // Only the CK-up, CK#-down crossing samples inputs; the other direction times read data.
    assign ck_rise  = (ck_prev == 2'h1) && ({f_ck, f_ck_n} == 2'h2);
    assign ck_fall  = (ck_prev == 2'h2) && ({f_ck, f_ck_n} == 2'h1);
    assign dqs_edge = (f_dqs != dqs_prev) && (pwr_state == ddr2_cmd_pkg::PWR_ACTIVE);

    // ****************************************************************
    // Command decode
    // ****************************************************************
    ddr2_cmd_pkg::cmd_e next_code;

    // Chip select is the top bit of the code, so a deselect is simply one of the decoded values.
    always_comb begin
        unique case (f_code)
            4'h7:    next_code = ddr2_cmd_pkg::CMD_NOP;
            4'h3:    next_code = ddr2_cmd_pkg::CMD_ACTIVATE;
            4'h5:    next_code = ddr2_cmd_pkg::CMD_READ;
            4'h4:    next_code = ddr2_cmd_pkg::CMD_WRITE;
            4'h2:    next_code = ddr2_cmd_pkg::CMD_PRECHARGE;
            4'h1:    next_code = ddr2_cmd_pkg::CMD_REFRESH;
            4'h0:    next_code = ddr2_cmd_pkg::CMD_MODE_SET;
            4'h6:    next_code = ddr2_cmd_pkg::CMD_NOP;
            default: next_code = ddr2_cmd_pkg::CMD_DESELECT;
        endcase
    end

    logic cmd_take;
    assign cmd_take = ck_rise && (pwr_state == ddr2_cmd_pkg::PWR_ACTIVE) && f_cke;

    // A command is reported only for live codes; a deselect leaves the outputs untouched.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd       <= '0;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= cmd_take && (next_code != ddr2_cmd_pkg::CMD_DESELECT)
                         && (next_code != ddr2_cmd_pkg::CMD_NOP);
            if (cmd_take && next_code != ddr2_cmd_pkg::CMD_DESELECT) begin
                cmd.code     <= next_code;
                cmd.bank     <= f_ba;
                cmd.addr     <= f_addr;
                cmd.pchg_all <= f_addr[ddr2_cmd_pkg::PCHG_ALL_BIT];
                cmd.ext_mode <= f_ba != ddr2_cmd_pkg::BA_BASE_MODE;
            end
        end
    end

    // ****************************************************************
    // Bank state and extended mode termination setting
    // ****************************************************************
    logic odt_enabled;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bank_open <= ddr2_cmd_pkg::BANK_OPEN_RST;
        end else if (cmd_take) begin
            if (next_code == ddr2_cmd_pkg::CMD_ACTIVATE) begin
                bank_open[f_ba] <= 1'b1;
            end else if (next_code == ddr2_cmd_pkg::CMD_PRECHARGE) begin
                if (f_addr[ddr2_cmd_pkg::PCHG_ALL_BIT]) begin
                    bank_open <= '0;
                end else begin
                    bank_open[f_ba] <= 1'b0;
                end
            end
        end
    end

    // Only extended register 1 carries the termination field; other mode sets leave it alone.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            odt_enabled <= ddr2_cmd_pkg::ODT_ENABLED_RST;
        end else if (cmd_take && next_code == ddr2_cmd_pkg::CMD_MODE_SET
                     && f_ba == ddr2_cmd_pkg::BA_EXT_MODE1) begin
            odt_enabled <= f_addr[ddr2_cmd_pkg::RTT_LO_BIT] | f_addr[ddr2_cmd_pkg::RTT_HI_BIT];
        end
    end

    // ****************************************************************
    // Power state machine and buffer gating
    // ****************************************************************
    // Entry and power-down exit look at CKE only on a sampling crossing; self-refresh exit
    // watches the filtered CKE level directly, since the clock may be stopped there.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_state <= ddr2_cmd_pkg::PWR_ACTIVE;
        end else begin
            case (pwr_state)
                ddr2_cmd_pkg::PWR_ACTIVE: begin
                    if (ck_rise && !f_cke) begin
                        if (next_code == ddr2_cmd_pkg::CMD_REFRESH && bank_open == '0) begin
                            pwr_state <= ddr2_cmd_pkg::PWR_SELF_REFRESH;
                        end else if (bank_open != '0) begin
                            pwr_state <= ddr2_cmd_pkg::PWR_ACTIVE_PD;
                        end else begin
                            pwr_state <= ddr2_cmd_pkg::PWR_PRECHARGE_PD;
                        end
                    end
                end
                ddr2_cmd_pkg::PWR_ACTIVE_PD, ddr2_cmd_pkg::PWR_PRECHARGE_PD: begin
                    if (ck_rise && f_cke) begin
                        pwr_state <= ddr2_cmd_pkg::PWR_ACTIVE;
                    end
                end
                default: begin
                    if (f_cke) begin
                        pwr_state <= ddr2_cmd_pkg::PWR_ACTIVE;
                    end
                end
            endcase
        end
    end

    // Enables follow the state registered one cycle earlier, so they lag it by a cycle.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_en     <= 1'b1;
            cmd_buf_en <= 1'b1;
            ctl_buf_en <= 1'b1;
            drv_en     <= 1'b1;
        end else begin
            clk_en     <= pwr_state == ddr2_cmd_pkg::PWR_ACTIVE;
            drv_en     <= pwr_state == ddr2_cmd_pkg::PWR_ACTIVE;
            cmd_buf_en <= pwr_state == ddr2_cmd_pkg::PWR_ACTIVE;
            ctl_buf_en <= pwr_state != ddr2_cmd_pkg::PWR_SELF_REFRESH;
        end
    end

    // ****************************************************************
    // On-die termination
    // ****************************************************************
    // ODT is registered on the sampling crossing and stays live in power-down, not in self refresh.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            term_en <= '0;
        end else if (!odt_enabled || pwr_state == ddr2_cmd_pkg::PWR_SELF_REFRESH) begin
            term_en <= '0;
        end else if (ck_rise) begin
            term_en <= {TW{f_odt}};
        end
    end

    // ****************************************************************
    // Write data capture with masking
    // ****************************************************************
    logic [$clog2(BURST_BEATS+1)-1:0] beats_left;

    // The window opens on a write command and closes after one burst of strobe edges.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            beats_left <= '0;
        end else if (cmd_take && next_code == ddr2_cmd_pkg::CMD_WRITE) begin
            beats_left <= ($clog2(BURST_BEATS+1))'(BURST_BEATS);
        end else if (dqs_edge && beats_left != '0) begin
            beats_left <= beats_left - 1'b1;
        end
    end

    // Each strobe edge is one beat; a byte lane whose mask is high is dropped.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_data  <= '0;
            wr_strb  <= '0;
            wr_valid <= 1'b0;
        end else begin
            wr_valid <= dqs_edge && beats_left != '0 && f_dm != '1;
            if (dqs_edge && beats_left != '0) begin
                wr_data <= f_dq;
                wr_strb <= ~f_dm;
            end
        end
    end

    // ****************************************************************
    // Read data output
    // ****************************************************************
    // The low half leaves on the rising crossing and the high half on the falling one.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dq_out <= '0;
            dq_oe  <= 1'b0;
        end else begin
            if (ck_rise) begin
                dq_out <= rd_data[ddr2_cmd_pkg::DQ_W-1:0];
                dq_oe  <= rd_en && drv_en;
            end else if (ck_fall) begin
                dq_out <= rd_data[2*ddr2_cmd_pkg::DQ_W-1:ddr2_cmd_pkg::DQ_W];
                dq_oe  <= rd_en && drv_en;
            end
        end
    end

endmodule : ddr2_cmd_ctrl

// >>> shared/ddr2_cmd_pkg.sv
// Shared types and constants for the DDR2 command and control input front end.
package ddr2_cmd_pkg;

    // ****************************************************************
    // Widths and counts
    // ****************************************************************
    localparam int ADDR_W     = 13;
    localparam int BANK_W     = 2;
    localparam int NUM_BANKS  = 4;
    localparam int DQ_W       = 16;
    localparam int DM_W       = 2;
    localparam int BURST_BEATS = 4;
    localparam int PCHG_ALL_BIT = 10;
    // Pin bundle: ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm, dqs, dq.
    localparam int PIN_W      = 8 + BANK_W + ADDR_W + DM_W + 1 + DQ_W;

    // ****************************************************************
    // Extended mode register termination field and reset values
    // ****************************************************************
    localparam int RTT_LO_BIT = 2;
    localparam int RTT_HI_BIT = 6;
    localparam logic [BANK_W-1:0] BA_BASE_MODE = 2'h0;
    localparam logic [BANK_W-1:0] BA_EXT_MODE1 = 2'h1;
    localparam logic             ODT_ENABLED_RST = 1'h0;
    localparam logic [NUM_BANKS-1:0] BANK_OPEN_RST = 4'h0;

    // ****************************************************************
    // Command and power state encodings
    // ****************************************************************
    typedef enum logic [3:0] {
        CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
        CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_SET
    } cmd_e;

    typedef enum logic [1:0] {
        PWR_ACTIVE, PWR_ACTIVE_PD, PWR_PRECHARGE_PD, PWR_SELF_REFRESH
    } pwr_e;

    typedef struct packed {
        cmd_e                     code;
        logic [BANK_W-1:0]        bank;
        logic [ADDR_W-1:0]        addr;
        logic                     pchg_all;
        logic                     ext_mode;
    } cmd_s;

endpackage : ddr2_cmd_pkg

// >>> verification/ddr2_cmd_ctrl_sva.sv
// Concurrent checks on the DDR2 command front end, bound to its ports.
`timescale 1ns/1ns
module ddr2_cmd_ctrl_sva (
    input wire logic               ref_clk,
    input wire logic               sys_rst,
    input wire ddr2_cmd_pkg::cmd_s cmd,
    input wire logic               cmd_valid,
    input wire logic [3:0]         bank_open,
    input wire ddr2_cmd_pkg::pwr_e pwr_state,
    input wire logic               clk_en,
    input wire logic               drv_en,
    input wire logic               cmd_buf_en,
    input wire logic               ctl_buf_en,
    input wire logic [19:0]        term_en,
    input wire logic [1:0]         wr_strb,
    input wire logic               wr_valid
);
    // ****************************************************************
    // Power state steps, the properties built on them, and command, bank, termination and write checks
    // ****************************************************************
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // The gates lag the state by one cycle, so each check looks one cycle past the step.
    sequence s_leave_active;
        pwr_state == ddr2_cmd_pkg::PWR_ACTIVE ##1 pwr_state != ddr2_cmd_pkg::PWR_ACTIVE;
    endsequence
    sequence s_enter_sr;
        pwr_state != ddr2_cmd_pkg::PWR_SELF_REFRESH ##1 pwr_state == ddr2_cmd_pkg::PWR_SELF_REFRESH;
    endsequence
    gate_off_a: assert property (s_leave_active |=> !clk_en && !drv_en && !cmd_buf_en)
        else $error("gates still on after leaving active");
    sr_shut_a: assert property (s_enter_sr |=> !ctl_buf_en && term_en == 20'h0)
        else $error("buffers or termination on in self refresh");
    pd_ctl_a: assert property ((pwr_state != ddr2_cmd_pkg::PWR_SELF_REFRESH) [*2] |-> ctl_buf_en)
        else $error("control buffers off outside self refresh");
    act_gate_a: assert property (cmd_valid |-> $past(pwr_state) == ddr2_cmd_pkg::PWR_ACTIVE)
        else $error("command taken outside active state");
    pulse_once_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse longer than one cycle");
    code_real_a: assert property (cmd_valid |-> cmd.code > ddr2_cmd_pkg::CMD_NOP)
        else $error("pulse on a masked or idle code");
    mode_sel_a: assert property (cmd_valid && cmd.code == ddr2_cmd_pkg::CMD_MODE_SET
        |-> cmd.ext_mode == (cmd.bank != 2'h0)) else $error("mode register choice wrong");
    act_open_a: assert property (cmd_valid && cmd.code == ddr2_cmd_pkg::CMD_ACTIVATE
        |-> bank_open[cmd.bank]) else $error("activated bank not open");
    pchg_all_a: assert property (cmd_valid && cmd.code == ddr2_cmd_pkg::CMD_PRECHARGE && cmd.pchg_all
        |-> bank_open == 4'h0) else $error("banks open after precharge all");
    term_whole_a: assert property (term_en == 20'h0 || term_en == 20'hfffff)
        else $error("termination applied to part of the lines");
    mask_drop_a: assert property (wr_valid |-> wr_strb != 2'h0)
        else $error("fully masked beat passed on");
endmodule : ddr2_cmd_ctrl_sva
bind ddr2_cmd_ctrl ddr2_cmd_ctrl_sva u_sva (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd(cmd), .cmd_valid(cmd_valid), .bank_open(bank_open),
    .pwr_state(pwr_state), .clk_en(clk_en), .drv_en(drv_en), .cmd_buf_en(cmd_buf_en),
    .ctl_buf_en(ctl_buf_en), .term_en(term_en), .wr_strb(wr_strb), .wr_valid(wr_valid)
);

// >>> verification/ddr2_host_model.sv
// Behavioural memory controller driving the DDR2 clock, command and write pins.
`timescale 1ns/1ns
module ddr2_host_model (
    input  wire logic ref_clk,
    output logic      ck,
    output logic      ck_n,
    output logic      cke,
    output logic      cs_n,
    output logic      ras_n,
    output logic      cas_n,
    output logic      we_n,
    output logic      odt,
    output logic [1:0]  ba,
    output logic [12:0] addr,
    output logic [1:0]  dm,
    output logic        dqs,
    output logic [15:0] dq_in
);
    // Clock parked low and the chip deselected until the first command.
    initial begin
        {ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dqs} = 9'b011111100;
        {ba, addr, dm, dq_in} = 33'h0;
    end
    // Next planned rising crossing, so that back-to-back commands keep the 125 ns link period.
    time t_rise = 0;
    // One link clock period with one command; released lines show the inverse, except chip select, which goes high, and CKE, which holds.
    task automatic tick(input logic [3:0] p, input logic [1:0] b, input logic [12:0] a, input logic k,
                        input logic o);
        @(negedge ref_clk);
        if (t_rise < $time + 10) t_rise = $time + 22; // The odd offset keeps crossings off system clock edges.
        {cs_n, ras_n, cas_n, we_n} = p;
        {ba, addr, cke, odt} = {b, a, k, o};
        #(t_rise - $time) {ck, ck_n} = 2'b10;
        #62 {ck, ck_n} = 2'b01;
        @(negedge ref_clk);
        {cs_n, ras_n, cas_n, we_n} = {1'b1, ~p[2:0]};
        {ba, addr, odt} = {~b, ~a, ~o};
        t_rise += 125;
    endtask : tick
    // Clock enable alone, used to leave self refresh with the clock parked.
    task automatic cke_set(input logic k);
        @(negedge ref_clk);
        cke = k;
    endtask : cke_set
    // One write beat with its own mask, set up well ahead of the strobe edge and held past it.
    task automatic beat(input logic [15:0] d, input logic [1:0] m);
        @(negedge ref_clk);
        cke = 1'b1;
        {dq_in, dm} = {d, m};
        #30 dqs = ~dqs;
        #55 {dq_in, dm} = {~d, ~m};
    endtask : beat
endmodule : ddr2_host_model

// >>> verification/test_ddr2_cmd_ctrl.sv
// Self-checking bench for the DDR2 command front end with a controller model on the pins.
`timescale 1ns/1ns
module test_ddr2_cmd_ctrl;
    logic               ref_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               rd_en = 1'b0;
    logic [31:0]        rd_data = 32'h0;
    wire                ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dqs, dq_oe, cmd_valid, wr_valid;
    wire                clk_en, cmd_buf_en, ctl_buf_en, drv_en;
    wire [1:0]          ba, dm, wr_strb;
    wire [3:0]          bank_open;
    wire [12:0]         addr;
    wire [15:0]         dq_in, dq_out, wr_data;
    wire [19:0]         term_en;
    ddr2_cmd_pkg::cmd_s cmd;
    ddr2_cmd_pkg::pwr_e pwr_state;
    ddr2_cmd_pkg::cmd_s exp_cmd = '0;
    int                 n_fail = 0, samples_checked = 0, pulses = 0, exp_pulses = 0, seed = 32'h79ab;
    logic [3:0]         exp_open = 4'h0, p;
    logic               odt_on = 1'b0, o;
    logic [17:0]        wq[$], eq[$];
    logic [15:0]        d;
    logic [1:0]         m;

    ddr2_host_model u_host (.ref_clk(ref_clk), .ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba), .addr(addr), .dm(dm), .dqs(dqs), .dq_in(dq_in));
    ddr2_cmd_ctrl #(.BURST_BEATS(4)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ck(ck), .ck_n(ck_n),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba), .addr(addr),
        .dm(dm), .dqs(dqs), .dq_in(dq_in), .rd_data(rd_data), .rd_en(rd_en), .dq_out(dq_out), .dq_oe(dq_oe),
        .cmd(cmd), .cmd_valid(cmd_valid), .bank_open(bank_open), .pwr_state(pwr_state), .clk_en(clk_en),
        .cmd_buf_en(cmd_buf_en), .ctl_buf_en(ctl_buf_en), .drv_en(drv_en), .term_en(term_en),
        .wr_data(wr_data), .wr_strb(wr_strb), .wr_valid(wr_valid));

    // 100 MHz system clock.
    always #5 ref_clk = ~ref_clk;
    // Pulses and beats are counted at the edge, so one-cycle outputs are never missed.
    always @(posedge ref_clk) begin
        if (cmd_valid === 1'b1) pulses <= pulses + 1;
        if (wr_valid === 1'b1) wq.push_back({wr_strb, wr_data});
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    // Expected command from the four command pins, chip select as the top bit.
    function automatic ddr2_cmd_pkg::cmd_e f_code(input logic [3:0] c);
        case (c)
            4'h0: return ddr2_cmd_pkg::CMD_MODE_SET;
            4'h1: return ddr2_cmd_pkg::CMD_REFRESH;
            4'h2: return ddr2_cmd_pkg::CMD_PRECHARGE;
            4'h3: return ddr2_cmd_pkg::CMD_ACTIVATE;
            4'h4: return ddr2_cmd_pkg::CMD_WRITE;
            4'h5: return ddr2_cmd_pkg::CMD_READ;
            4'h6, 4'h7: return ddr2_cmd_pkg::CMD_NOP;
            default: return ddr2_cmd_pkg::CMD_DESELECT;
        endcase
    endfunction : f_code
    // One command in the active state; the expected bank, mode and termination state move with it.
    task automatic run_cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic t);
        ddr2_cmd_pkg::cmd_e k;
        logic [19:0]        te;
        k = f_code(c);
        te = (odt_on && t) ? 20'hfffff : 20'h0;
        if (k != ddr2_cmd_pkg::CMD_DESELECT) exp_cmd = '{k, b, a, a[10], b != 2'h0};
        if (k > ddr2_cmd_pkg::CMD_NOP) exp_pulses++;
        if (k == ddr2_cmd_pkg::CMD_ACTIVATE) exp_open[b] = 1'b1;
        if (k == ddr2_cmd_pkg::CMD_PRECHARGE) exp_open = a[10] ? 4'h0 : exp_open & ~(4'h1 << b);
        if (k == ddr2_cmd_pkg::CMD_MODE_SET && b == 2'h1) odt_on = a[2] | a[6];
        u_host.tick(c, b, a, 1'b1, t);
        chk("cmd", exp_cmd, cmd);
        chk("pulses", exp_pulses, pulses);
        chk("bank_open", exp_open, bank_open);
        chk("term_en", te, term_en);
    endtask : run_cmd

    // Watchdog: far beyond the fewer than one hundred link periods the tests need.
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
    // Main sequence: reset, every code, termination, random traffic, writes, reads, power states.
    initial begin
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk("rst_out", 32'h0, {pwr_state, bank_open, term_en, cmd_valid});
        chk("rst_gates", 4'hf, {clk_en, drv_en, cmd_buf_en, ctl_buf_en});
        repeat (5) @(negedge ref_clk);
        for (int i = 0; i < 16; i++) run_cmd(4'(i), 2'(i), 13'(i * 341), 1'b0);
        run_cmd(4'h0, 2'h1, 13'h0004, 1'b0);
        run_cmd(4'h7, 2'h0, 13'h0, 1'b1);
        run_cmd(4'h0, 2'h1, 13'h0000, 1'b0);
        run_cmd(4'h7, 2'h0, 13'h0, 1'b1);
        for (int i = 0; i < 40; i++) begin
            p = 4'($random(seed));
            o = 1'($random(seed)) & (p != 4'h0);
            run_cmd(p, 2'($random(seed)), 13'($random(seed)), o);
        end
        // A burst of four beats, one fully masked, and a stray fifth edge that must be dropped.
        run_cmd(4'h4, 2'h2, 13'h0, 1'b0);
        wq.delete();
        for (int i = 0; i < 5; i++) begin
            d = 16'($random(seed));
            m = (i == 1) ? 2'h3 : 2'($random(seed));
            u_host.beat(d, m);
            if (i < 4 && m != 2'h3) eq.push_back({~m, d});
        end
        repeat (8) @(negedge ref_clk);
        chk("beats", eq.size(), wq.size());
        foreach (eq[i]) chk("beat", eq[i], wq[i]);
        rd_en = 1'b1;
        rd_data = $random(seed);
        fork
            run_cmd(4'h7, 2'h0, 13'h0, 1'b0);
            begin
                @(posedge ck);
                #56 chk("dq_rise", rd_data[15:0], dq_out);
            end
        join
        repeat (6) @(negedge ref_clk);
        chk("dq_fall", {1'b1, rd_data[31:16]}, {dq_oe, dq_out});
        rd_en = 1'b0;
        // Active power-down with a row open; a command while down is ignored.
        run_cmd(4'h2, 2'h0, 13'h0400, 1'b0);
        run_cmd(4'h3, 2'h1, 13'h0123, 1'b0);
        u_host.tick(4'h7, 2'h0, 13'h0, 1'b0, 1'b0);
        chk("pwr", ddr2_cmd_pkg::PWR_ACTIVE_PD, pwr_state);
        chk("gates", 4'h1, {clk_en, drv_en, cmd_buf_en, ctl_buf_en});
        u_host.tick(4'h3, 2'h2, 13'h0, 1'b0, 1'b0);
        u_host.tick(4'h7, 2'h0, 13'h0, 1'b1, 1'b0);
        chk("pwr", ddr2_cmd_pkg::PWR_ACTIVE, pwr_state);
        chk("bank_open", exp_open, bank_open);
        run_cmd(4'h2, 2'h0, 13'h0400, 1'b0);
        u_host.tick(4'h7, 2'h0, 13'h0, 1'b0, 1'b0);
        chk("pwr", ddr2_cmd_pkg::PWR_PRECHARGE_PD, pwr_state);
        u_host.tick(4'h7, 2'h0, 13'h0, 1'b1, 1'b0);
        u_host.tick(4'h1, 2'h0, 13'h0, 1'b0, 1'b0);
        chk("pwr", ddr2_cmd_pkg::PWR_SELF_REFRESH, pwr_state);
        chk("gates", 4'h0, {clk_en, drv_en, cmd_buf_en, ctl_buf_en});
        u_host.cke_set(1'b1);
        for (int i = 0; i < 20 && pwr_state !== ddr2_cmd_pkg::PWR_ACTIVE; i++) @(negedge ref_clk);
        chk("pwr", ddr2_cmd_pkg::PWR_ACTIVE, pwr_state);
        run_cmd(4'h3, 2'h3, 13'h0042, 1'b0);
        wrap_up();
    end
endmodule : test_ddr2_cmd_ctrl
